// *** rtl/pfto_filter.sv ***
`timescale 1ns/100ps
`default_nettype none
module pfto_filter
	import pfto_pkg::*;
#(
	parameter int CH = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// filter signals
	pfto_if.flt f
);
	genvar g;
	generate
		for (g = 0; g < CH; g++) begin : gch
			logic [THR_W-1:0] cnt_r; // cycles the input differs
			logic out_r; // accepted level
			logic gl_r; // discarded level pulse
			// count stable cycles, accept at threshold
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					cnt_r <= '0;
					out_r <= 1'b0;
					gl_r <= 1'b0;
				end else if (f.raw[g] == out_r) begin
					// level returned early: drop it
					gl_r <= (cnt_r != '0);
					cnt_r <= '0;
				end else if (cnt_r >= f.thr) begin
					// held long enough: pass it
					out_r <= f.raw[g];
					cnt_r <= '0;
					gl_r <= 1'b0;
				end else begin
					cnt_r <= cnt_r + 1'b1;
					gl_r <= 1'b0;
				end
			end
			assign f.filt[g] = out_r;
			assign f.glitch[g] = gl_r;
		end
	endgenerate
endmodule
`default_nettype wire

// *** rtl/pfto_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface pfto_if #(parameter int CH = 2, parameter int THR_W = 14);
	logic [THR_W-1:0] thr; // filter threshold in cycles
	logic [CH-1:0] raw; // synchronised pulse inputs
	logic [CH-1:0] filt; // filtered pulse outputs
	logic [CH-1:0] glitch; // pulse per discarded level
	logic signed [31:0] turns; // multi-turn count
	logic enc_abs; // encoder is absolute
	logic abs_ok; // absolute encoder normal
	logic [15:0] rot_limit; // rotation limit setting
	logic report_off; // overflow reporting suppressed
	logic fault; // overflow fault level
	modport ctl(output thr, raw, turns, enc_abs, abs_ok, rot_limit, report_off, input filt, glitch, fault);
	modport flt(input thr, raw, output filt, glitch);
	modport mon(input turns, enc_abs, abs_ok, rot_limit, report_off, output fault);
endinterface
`default_nettype wire

// *** rtl/pfto_ovf_mon.sv ***
`timescale 1ns/100ps
`default_nettype none
module pfto_ovf_mon
	import pfto_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// monitor signals
	pfto_if.mon m
);
	logic active; // monitoring enabled
	logic outside; // count out of range
	logic fault_r; // registered fault
	// both flags must be one, no rotation limit, reporting on
	always_comb begin
		active = m.enc_abs && m.abs_ok;
		active = active && (m.rot_limit == 16'h0000);
		active = active && !m.report_off;
		outside = (m.turns < TURN_MIN) || (m.turns > TURN_MAX);
	end
	// fault follows the range check while active
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_r <= 1'b0;
		end else begin
			fault_r <= active && outside;
		end
	end
	assign m.fault = fault_r;
endmodule
`default_nettype wire

// *** rtl/pfto_pkg.sv ***
package pfto_pkg;
	// register indexes; byte address is four times the index
	localparam logic [7:0] IDX_SWITCH_E = 8'h0e;
	localparam logic [7:0] IDX_FILTER_W = 8'h11;
	localparam logic [7:0] IDX_STATUS = 8'h20;
	localparam logic [7:0] IDX_MASK = 8'h21;
	localparam logic [7:0] IDX_TURNS = 8'h22;
	// reset values and filter width limit
	localparam logic [15:0] SWITCH_E_RST = 16'h4000;
	localparam logic [15:0] FILTER_W_RST = 16'h0190;
	localparam logic [15:0] FILTER_W_MAX = 16'h1388;
	// switch word digit positions
	localparam int DIG_REPORT = 0;
	localparam int DIG_VMATCH = 4;
	localparam int DIG_ENCTYPE = 8;
	localparam int DIG_RES = 12;
	// status and mask bit positions
	localparam int ST_OVF = 0;
	localparam int ST_GLITCH = 1;
	localparam int ST_W = 2;
	// turn count limits
	localparam logic signed [31:0] TURN_MIN = -32'sd32768;
	localparam logic signed [31:0] TURN_MAX = 32'sd32767;
	// filter timing: one step is 12.5 ns, clock period 10 ns
	localparam int STEP_PS = 12500;
	localparam int CLK_PS = 10000;
	localparam int THR_W = 14;
	// resolution codes to bit counts
	function automatic logic [4:0] res_bits(input logic [3:0] code);
		case (code)
			4'h0: res_bits = 5'h10;
			4'h1: res_bits = 5'h11;
			4'h2: res_bits = 5'h14;
			4'h3: res_bits = 5'h17;
			default: res_bits = 5'h18;
		endcase
	endfunction
	// filter setting to whole clock cycles, rounded up
	function automatic logic [THR_W-1:0] steps_to_cycles(input logic [15:0] s);
		logic [31:0] p;
		p = 32'(s) * 32'(STEP_PS) + 32'(CLK_PS - 1);
		steps_to_cycles = THR_W'(p / 32'(CLK_PS));
	endfunction
endpackage

// *** rtl/pfto_top.sv ***
// What this block does
// - report switch 0 reports, 1 suppresses overflow
// - voltage match check on at 0
// - encoder type 0 incremental, 1 absolute
// - codes 0..4 give 16,17,20,23,24 bits
// - monitor only when absolute and normal
// - fault when turns outside -32768..32767
// - nonzero rotation limit disables overflow fault
// - filter width 0..5000, 12.5 ns, default 400
// - shorter levels discarded as interference
// - longer high and low phases pass
`timescale 1ns/100ps
`default_nettype none
module pfto_top
	import pfto_pkg::*;
#(
	parameter int CH = 2
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RSTN,
	// wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [9:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// pulse command pins
	input wire logic [CH-1:0] PULSE_IN,
	output logic [CH-1:0] PULSE_FILT,
	// encoder state from other logic
	input wire logic signed [31:0] TURN_COUNT,
	input wire logic ENCODER_ABSOLUTE_FLAG,
	input wire logic ABSOLUTE_ENCODER_NORMAL_FLAG,
	input wire logic [15:0] ROTATION_LIMIT_SETTING,
	// fault and configuration outputs
	output logic MULTITURN_OVERFLOW_FAULT,
	output logic VOLT_MATCH_CHECK_EN,
	output logic SIM_ENC_ABSOLUTE,
	output logic [4:0] SIM_ENC_RES_BITS,
	// interrupt
	output logic IRQ
);
	pfto_if #(.CH(CH), .THR_W(THR_W)) bus_if();

	logic [15:0] switch_e_r; // basic_function_switch_e
	logic [15:0] filter_w_r; // pulse_filter_width
	logic [THR_W-1:0] thr_r; // threshold in cycles
	logic [ST_W-1:0] status_r; // sticky events
	logic [ST_W-1:0] mask_r; // interrupt enables
	logic ack_r; // bus answer
	logic [31:0] rdata_r; // bus read data
	logic [CH-1:0] sync1_r; // first sync stage
	logic [CH-1:0] sync2_r; // second sync stage
	logic fault_d_r; // fault delayed for edge
	logic req; // a new bus access
	logic wr; // a write this cycle
	logic [7:0] idx; // word index
	logic [ST_W-1:0] ev; // event pulses
	logic [15:0] wdata16; // write data after byte enables
	logic [15:0] fw_in; // filter write, clamped

	assign req = WB_CYC_I && WB_STB_I && !ack_r;
	assign wr = req && WB_WE_I;
	assign idx = WB_ADR_I[9:2];

	// merge write data into a 16-bit word using byte selects
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		merge16 = old;
		if (s[0]) begin
			merge16[7:0] = d[7:0];
		end
		if (s[1]) begin
			merge16[15:8] = d[15:8];
		end
	endfunction

	// filter width write, held inside its range
	always_comb begin
		fw_in = merge16(filter_w_r, WB_DAT_I, WB_SEL_I);
		if (fw_in > FILTER_W_MAX) begin
			fw_in = FILTER_W_MAX;
		end
		wdata16 = merge16(switch_e_r, WB_DAT_I, WB_SEL_I);
	end

	// two-stage synchroniser on the pulse pins
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= PULSE_IN;
			sync2_r <= sync1_r;
		end
	end

	// wishbone answer, one cycle after the request
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req;
		end
	end

	// switch word
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			switch_e_r <= SWITCH_E_RST;
		end else if (wr && idx == IDX_SWITCH_E) begin
			switch_e_r <= wdata16;
		end
	end

	// filter width setting
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			filter_w_r <= FILTER_W_RST;
		end else if (wr && idx == IDX_FILTER_W) begin
			filter_w_r <= fw_in;
		end
	end

	// filter time converted to clock cycles
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			thr_r <= '0;
		end else begin
			thr_r <= steps_to_cycles(filter_w_r);
		end
	end

	// event pulses: fault rising, any discarded glitch
	always_comb begin
		ev = '0;
		ev[ST_OVF] = bus_if.fault && !fault_d_r;
		ev[ST_GLITCH] = |bus_if.glitch;
	end

	// fault edge history
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			fault_d_r <= 1'b0;
		end else begin
			fault_d_r <= bus_if.fault;
		end
	end

	// sticky status, write one to clear, set wins
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			status_r <= '0;
		end else if (wr && idx == IDX_STATUS && WB_SEL_I[0]) begin
			status_r <= (status_r & ~WB_DAT_I[ST_W-1:0]) | ev;
		end else begin
			status_r <= status_r | ev;
		end
	end

	// interrupt mask
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			mask_r <= '0;
		end else if (wr && idx == IDX_MASK && WB_SEL_I[0]) begin
			mask_r <= WB_DAT_I[ST_W-1:0];
		end
	end

	// read data, captured with the answer
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			rdata_r <= '0;
		end else if (req && !WB_WE_I) begin
			if (idx == IDX_SWITCH_E) begin
				rdata_r <= {16'h0000, switch_e_r};
			end else if (idx == IDX_FILTER_W) begin
				rdata_r <= {16'h0000, filter_w_r};
			end else if (idx == IDX_STATUS) begin
				rdata_r <= {{(32-ST_W){1'b0}}, status_r};
			end else if (idx == IDX_MASK) begin
				rdata_r <= {{(32-ST_W){1'b0}}, mask_r};
			end else if (idx == IDX_TURNS) begin
				rdata_r <= TURN_COUNT;
			end else begin
				// unmapped: reads zero
				rdata_r <= '0;
			end
		end
	end

	// drive the shared signals
	assign bus_if.thr = thr_r;
	assign bus_if.raw = sync2_r;
	assign bus_if.turns = TURN_COUNT;
	assign bus_if.enc_abs = ENCODER_ABSOLUTE_FLAG;
	assign bus_if.abs_ok = ABSOLUTE_ENCODER_NORMAL_FLAG;
	assign bus_if.rot_limit = ROTATION_LIMIT_SETTING;
	assign bus_if.report_off = switch_e_r[DIG_REPORT];

	// glitch filter
	pfto_filter #(.CH(CH)) u_filter (
		.clk(CLK_SYS),
		.rst_n(RSTN),
		.f(bus_if.flt)
	);

	// multi-turn overflow monitor
	pfto_ovf_mon u_mon (
		.clk(CLK_SYS),
		.rst_n(RSTN),
		.m(bus_if.mon)
	);

	// outputs
	assign WB_ACK_O = ack_r;
	assign WB_DAT_O = rdata_r;
	assign PULSE_FILT = bus_if.filt;
	assign MULTITURN_OVERFLOW_FAULT = bus_if.fault;
	assign VOLT_MATCH_CHECK_EN = !switch_e_r[DIG_VMATCH];
	assign SIM_ENC_ABSOLUTE = switch_e_r[DIG_ENCTYPE];
	assign SIM_ENC_RES_BITS = res_bits(switch_e_r[DIG_RES+:4]);
	assign IRQ = |(status_r & mask_r);
endmodule
`default_nettype wire

// *** tb/pfto_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module pfto_assertions
	import pfto_pkg::*;
#(
	parameter int CH = 2
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RSTN,
	// bus
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [9:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	// pulse path
	input wire logic [CH-1:0] PULSE_IN,
	input wire logic [CH-1:0] PULSE_FILT,
	// encoder state and outputs
	input wire logic signed [31:0] TURN_COUNT,
	input wire logic ENCODER_ABSOLUTE_FLAG,
	input wire logic ABSOLUTE_ENCODER_NORMAL_FLAG,
	input wire logic [15:0] ROTATION_LIMIT_SETTING,
	input wire logic MULTITURN_OVERFLOW_FAULT,
	input wire logic VOLT_MATCH_CHECK_EN,
	input wire logic SIM_ENC_ABSOLUTE,
	input wire logic [4:0] SIM_ENC_RES_BITS,
	input wire logic IRQ
);
	// one clock domain, checks off during reset
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RSTN);
	logic out_rng; // count outside the signed 16-bit span
	logic ovf_ok; // every condition for the fault except the report switch
	assign out_rng = TURN_COUNT < TURN_MIN || TURN_COUNT > TURN_MAX;
	assign ovf_ok = ENCODER_ABSOLUTE_FLAG && ABSOLUTE_ENCODER_NORMAL_FLAG && ROTATION_LIMIT_SETTING == 16'h0 && out_rng;
	a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("ack late");
	a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack too long");
	a_fault_cause: assert property (MULTITURN_OVERFLOW_FAULT |-> $past(ovf_ok))
		else $error("fault without cause");
	a_rot_off: assert property (ROTATION_LIMIT_SETTING != 16'h0 |=> !MULTITURN_OVERFLOW_FAULT)
		else $error("fault with rotation limit");
	a_range_quiet: assert property (!out_rng |=> !MULTITURN_OVERFLOW_FAULT)
		else $error("fault in range");
	a_res_legal: assert property (SIM_ENC_RES_BITS inside {5'h10, 5'h11, 5'h14, 5'h17, 5'h18})
		else $error("bad resolution");
	a_cfg_write: assert property ($changed({VOLT_MATCH_CHECK_EN, SIM_ENC_ABSOLUTE, SIM_ENC_RES_BITS})
		|-> WB_ACK_O && WB_WE_I)
		else $error("config moved without write");
	a_width_max: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I[9:2] == IDX_FILTER_W
		|-> WB_DAT_O[15:0] <= FILTER_W_MAX)
		else $error("width above limit");
	a_filt_source: assert property ($changed(PULSE_FILT[0]) |-> PULSE_FILT[0] == $past(PULSE_IN[0], 3))
		else $error("filtered level not from pin");
	c_fault: cover property ($rose(MULTITURN_OVERFLOW_FAULT));
	c_filt: cover property ($changed(PULSE_FILT[0]));
	c_irq: cover property ($rose(IRQ));
endmodule
bind pfto_top pfto_assertions #(.CH(CH)) u_pfto_assertions (.*);
`default_nettype wire

// *** tb/pfto_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pfto_host_model (
	// clock
	input wire logic clk,
	// train control, phase lengths in cycles
	input wire logic go,
	input wire logic [7:0] hi,
	input wire logic [7:0] lo,
	// pulse lines, both carry the train
	output logic [1:0] pin
);
	logic lvl_r; // present level
	logic [7:0] cnt_r; // cycles left in phase
	// alternate phases while go, rest low otherwise
	always_ff @(posedge clk) begin
		if (!go) begin
			lvl_r <= 1'b0;
			cnt_r <= 8'h01;
		end else if (cnt_r <= 8'h01) begin
			lvl_r <= !lvl_r;
			cnt_r <= lvl_r ? lo : hi;
		end else begin
			cnt_r <= cnt_r - 8'h01;
		end
	end
	assign pin = {lvl_r, lvl_r};
endmodule
`default_nettype wire

// *** tb/tb_pulse_filter_and_turn_overflow.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_pulse_filter_and_turn_overflow
	import pfto_pkg::*;
();
	// address, write value, config, turns, {abs, normal, limit}, fault
	typedef struct packed {logic [9:0] a; logic [15:0] w; logic [6:0] c;
		logic [31:0] t; logic [2:0] e; logic f;} pfto_row_t;
	localparam int W = 4; // filter setting for pulse tests, kept just below 40000/f plus 1
	localparam int THR = (W * 5 + 3) / 4; // cycles a level must outlast
	logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [31:0] wd = 32'h0, rd;
	logic [1:0] pin, filt;
	logic signed [31:0] turns = 32'sh0;
	logic enc = 1'b0, nrm = 1'b0, go = 1'b0, ack, fault, vm, sa, irq;
	logic [15:0] rot = 16'h0, q;
	logic [7:0] hl = 8'h01;
	logic [4:0] rb;
	int mismatches = 0, comparisons = 0, n;
	pfto_row_t rows [10] = '{
		'{10'h044, 16'h1388, 7'h58, 32'h0, 3'h6, 1'b0},
		'{10'h03c, 16'h1234, 7'h58, 32'h0, 3'h6, 1'b0},
		'{10'h038, 16'h0000, 7'h50, 32'h7fff, 3'h6, 1'b0},
		'{10'h038, 16'h1000, 7'h51, 32'h8000, 3'h6, 1'b1},
		'{10'h038, 16'h2000, 7'h54, 32'hffff8000, 3'h6, 1'b0},
		'{10'h038, 16'h3000, 7'h57, 32'hffff7fff, 3'h6, 1'b1},
		'{10'h038, 16'h5110, 7'h38, 32'h8000, 3'h2, 1'b0},
		'{10'h038, 16'h0000, 7'h50, 32'h8000, 3'h4, 1'b0},
		'{10'h038, 16'h0001, 7'h50, 32'h8000, 3'h6, 1'b0},
		'{10'h038, 16'h0000, 7'h50, 32'h8000, 3'h7, 1'b0}};
	always #5 clk = !clk; // 100 MHz
	pfto_top u_pfto_top (.CLK_SYS(clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(4'h3), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack), .PULSE_IN(pin),
		.PULSE_FILT(filt), .TURN_COUNT(turns), .ENCODER_ABSOLUTE_FLAG(enc), .ABSOLUTE_ENCODER_NORMAL_FLAG(nrm),
		.ROTATION_LIMIT_SETTING(rot), .MULTITURN_OVERFLOW_FAULT(fault), .VOLT_MATCH_CHECK_EN(vm),
		.SIM_ENC_ABSOLUTE(sa), .SIM_ENC_RES_BITS(rb), .IRQ(irq));
	pfto_host_model u_pfto_host_model (.clk(clk), .go(go), .hi(hl), .lo(hl), .pin(pin));
	// verdict and end of run
	task final_report;
		if (mismatches == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// compare one value
	task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		comparisons++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	// one classic bus cycle, read data kept in q
	task bus(input logic w, input logic [9:0] a, input logic [15:0] d);
		int i;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= {16'h0, d};
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (ack !== 1'b1 && i < 20);
		q = rd[15:0];
		if (i >= 20) begin
			mismatches++;
			final_report();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		final_report();
	end
	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk("config", 16'h0058, 16'({vm, sa, rb}));
		chk("irq", 16'h0, 16'(irq));
		bus(1'b0, 10'h038, 16'h0);
		chk("switch", 16'h4000, q);
		bus(1'b0, 10'h044, 16'h0);
		chk("width", 16'h0190, q);
		foreach (rows[k]) begin
			bus(1'b1, rows[k].a, rows[k].w);
			turns <= rows[k].t;
			{enc, nrm} <= rows[k].e[2:1];
			rot <= {15'h0, rows[k].e[0]};
			bus(1'b0, rows[k].a, 16'h0);
			chk("read", rows[k].a == 10'h03c ? 16'h0 : rows[k].w, q);
			chk("config", 16'(rows[k].c), 16'({vm, sa, rb}));
			chk("fault", 16'(rows[k].f), 16'(fault));
		end
		// turn count readback, low half of the last row's count
		bus(1'b0, 10'h088, 16'h0);
		chk("turns", 16'h8000, q);
		// sticky overflow record, mask and clear
		bus(1'b0, 10'h080, 16'h0);
		chk("status", 16'h0001, q);
		bus(1'b1, 10'h084, 16'h0001);
		chk("irq", 16'h1, 16'(irq));
		bus(1'b1, 10'h080, 16'h0001);
		chk("irq", 16'h0, 16'(irq));
		// levels just as long as the threshold are dropped
		bus(1'b1, 10'h044, 16'(W));
		hl <= 8'(THR);
		go <= 1'b1;
		n = 0;
		repeat (60) begin
			@(posedge clk);
			if (filt[0] !== 1'b0) n++;
		end
		go <= 1'b0;
		chk("dropped", 16'h0, 16'(n));
		bus(1'b0, 10'h080, 16'h0);
		chk("status", 16'h0002, q);
		// one cycle longer passes, with fixed latency
		hl <= 8'(THR + 1);
		go <= 1'b1;
		n = 0;
		while (pin[0] !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		n = 0;
		while (filt[0] !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		chk("latency", 16'(THR + 3), 16'(n));
		chk("lane1", 16'h1, 16'(filt[1]));
		repeat (THR + 2) @(posedge clk);
		chk("low phase", 16'h0, 16'(filt[0]));
		go <= 1'b0;
		final_report();
	end
endmodule
`default_nettype wire
